/* inc/ddu_pkg.sv */
// Constants for the dual converter update formatter
// How it works
// - A channel's enable bit at 0 turns its output pin off and shuts the converter down; at 1 the pin is active.
// - Control bits 6 and 5 read as zero and ignore writes.
// - In update mode 00 the code reaches the converter latch when software writes the high byte.
// - In modes 01, 10 and 11 the latch updates only on a timer 3, timer 4 or timer 2 overflow.
// - Format 000 takes the code from high bits 3:0 and the whole low byte.
// - Format 001 takes high bits 4:0 and low bits 7:1.
// - Format 010 takes high bits 5:0 and low bits 7:2.
// - Format 011 takes high bits 6:0 and low bits 7:3.
// - Any format with its top bit set takes the whole high byte and low bits 7:4.
// - The second channel has its own enable, mode and format fields and updates on its own high byte.
// - In write mode a low byte write is held until the high byte is written.
// - In timer modes both bytes are held and copied to the latch together on the chosen overflow.
// - The low register reads back the last written value; the high register reads its latch.
`default_nettype none

package ddu_pkg;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] CH0_CODE_LOW_BYTE     = 8'hd2;
	localparam logic [7:0] CH0_CODE_HIGH_BYTE    = 8'hd3;
	localparam logic [7:0] CH0_CONVERTER_CONTROL = 8'hd4;
	localparam logic [7:0] CH1_CODE_LOW_BYTE     = 8'hd5;
	localparam logic [7:0] CH1_CODE_HIGH_BYTE    = 8'hd6;
	localparam logic [7:0] CH1_CONVERTER_CONTROL = 8'hd7;

	// ----------------------------------------
	// Control fields and reset values
	// ----------------------------------------
	localparam int         ENABLE_BIT    = 7;
	localparam int         MODE_LSB      = 3;
	localparam int         FORMAT_LSB    = 0;
	localparam logic [7:0] CONTROL_MASK  = 8'h9f;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET    = 8'h00;
	localparam logic [11:0] CODE_RESET   = 12'h000;

	// ----------------------------------------
	// Update modes
	// ----------------------------------------
	localparam logic [1:0] MODE_ON_WRITE = 2'h0;
	localparam logic [1:0] MODE_TIMER3   = 2'h1;
	localparam logic [1:0] MODE_TIMER4   = 2'h2;
	localparam logic [1:0] MODE_TIMER2   = 2'h3;

endpackage

`default_nettype wire

/* verilog/ddu_channel.sv */
// One converter channel: control, data bytes, formatting and latch
`timescale 1ns/10ps
`default_nettype none

module ddu_channel (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Register writes decoded for this channel
	input  wire logic        wr_low,
	input  wire logic        wr_high,
	input  wire logic        wr_control,
	input  wire logic [7:0]  wr_data,
	// Timer overflow pulses
	input  wire logic        t2_pulse,
	input  wire logic        t3_pulse,
	input  wire logic        t4_pulse,
	// State
	output logic      [7:0]  low_byte,
	output logic      [7:0]  high_latch,
	output logic      [7:0]  control,
	output logic      [11:0] code
);

	// ----------------------------------------
	// Formatting
	// ----------------------------------------
	function automatic logic [11:0] ddu_format(input logic [2:0] fmt,
						   input logic [7:0] hi,
						   input logic [7:0] lo);
		logic [11:0] r;
		r = {hi, lo[7:4]};
		if (!fmt[2]) begin
			case (fmt[1:0])
				2'h0: r = {hi[3:0], lo};
				2'h1: r = {hi[4:0], lo[7:1]};
				2'h2: r = {hi[5:0], lo[7:2]};
				default: r = {hi[6:0], lo[7:3]};
			endcase
		end
		return r;
	endfunction

	logic [7:0] high_byte;
	logic [7:0] low_latch;

	wire logic [1:0] mode      = control[ddu_pkg::MODE_LSB +: 2];
	wire logic [2:0] fmt       = control[ddu_pkg::FORMAT_LSB +: 3];
	wire logic       timer_hit = (mode == ddu_pkg::MODE_TIMER3 && t3_pulse) ||
				     (mode == ddu_pkg::MODE_TIMER4 && t4_pulse) ||
				     (mode == ddu_pkg::MODE_TIMER2 && t2_pulse);
	wire logic       write_hit = (mode == ddu_pkg::MODE_ON_WRITE) && wr_high;
	// Write-mode transfer uses the byte being written so it lands in the same cycle
	wire logic [7:0] next_high = wr_high ? wr_data : high_byte;
	wire logic [7:0] next_low  = wr_low ? wr_data : low_byte;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			control    <= ddu_pkg::CONTROL_RESET;
			low_byte   <= ddu_pkg::DATA_RESET;
			high_byte  <= ddu_pkg::DATA_RESET;
			low_latch  <= ddu_pkg::DATA_RESET;
			high_latch <= ddu_pkg::DATA_RESET;
			code       <= ddu_pkg::CODE_RESET;
		end else begin
			if (wr_control) begin
				control <= wr_data & ddu_pkg::CONTROL_MASK;
			end
			low_byte  <= next_low;
			high_byte <= next_high;
			if (write_hit || timer_hit) begin
				low_latch  <= next_low;
				high_latch <= next_high;
			end
			code <= ddu_format(fmt, high_latch, low_latch);
		end
	end

endmodule

`default_nettype wire

/* verilog/ddu_top.sv */
// Dual converter update formatter: register port and two channels
`timescale 1ns/10ps
`default_nettype none

module ddu_top (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Special function register port
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	// Timer overflow pulses, one cycle each
	input  wire logic        timer2_overflow,
	input  wire logic        timer3_overflow,
	input  wire logic        timer4_overflow,
	// Converter side
	output logic      [11:0] ch0_code,
	output logic      [11:0] ch1_code,
	output logic             ch0_output_enable,
	output logic             ch1_output_enable,
	output logic             ch0_shutdown,
	output logic             ch1_shutdown
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire logic hit_l0 = sfr_addr == ddu_pkg::CH0_CODE_LOW_BYTE;
	wire logic hit_h0 = sfr_addr == ddu_pkg::CH0_CODE_HIGH_BYTE;
	wire logic hit_c0 = sfr_addr == ddu_pkg::CH0_CONVERTER_CONTROL;
	wire logic hit_l1 = sfr_addr == ddu_pkg::CH1_CODE_LOW_BYTE;
	wire logic hit_h1 = sfr_addr == ddu_pkg::CH1_CODE_HIGH_BYTE;
	wire logic hit_c1 = sfr_addr == ddu_pkg::CH1_CONVERTER_CONTROL;

	logic [7:0]  low0;
	logic [7:0]  high0;
	logic [7:0]  ctl0;
	logic [7:0]  low1;
	logic [7:0]  high1;
	logic [7:0]  ctl1;
	logic [11:0] code0;
	logic [11:0] code1;

	ddu_channel u_ch0 (
		.core_clk   (core_clk),
		.resetn     (resetn),
		.wr_low     (sfr_wr && hit_l0),
		.wr_high    (sfr_wr && hit_h0),
		.wr_control (sfr_wr && hit_c0),
		.wr_data    (sfr_wdata),
		.t2_pulse   (timer2_overflow),
		.t3_pulse   (timer3_overflow),
		.t4_pulse   (timer4_overflow),
		.low_byte   (low0),
		.high_latch (high0),
		.control    (ctl0),
		.code       (code0)
	);

	ddu_channel u_ch1 (
		.core_clk   (core_clk),
		.resetn     (resetn),
		.wr_low     (sfr_wr && hit_l1),
		.wr_high    (sfr_wr && hit_h1),
		.wr_control (sfr_wr && hit_c1),
		.wr_data    (sfr_wdata),
		.t2_pulse   (timer2_overflow),
		.t3_pulse   (timer3_overflow),
		.t4_pulse   (timer4_overflow),
		.low_byte   (low1),
		.high_latch (high1),
		.control    (ctl1),
		.code       (code1)
	);

	// ----------------------------------------
	// Read mux, registered
	// ----------------------------------------
	logic [7:0] rd_sel;
	always_comb begin
		if (hit_l0) begin
			rd_sel = low0;
		end else if (hit_h0) begin
			rd_sel = high0;
		end else if (hit_c0) begin
			rd_sel = ctl0;
		end else if (hit_l1) begin
			rd_sel = low1;
		end else if (hit_h1) begin
			rd_sel = high1;
		end else if (hit_c1) begin
			rd_sel = ctl1;
		end else begin
			rd_sel = 8'h00;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sfr_rdata         <= ddu_pkg::DATA_RESET;
			ch0_code          <= ddu_pkg::CODE_RESET;
			ch1_code          <= ddu_pkg::CODE_RESET;
			ch0_output_enable <= 1'h0;
			ch1_output_enable <= 1'h0;
			ch0_shutdown      <= 1'h1;
			ch1_shutdown      <= 1'h1;
		end else begin
			sfr_rdata         <= sfr_rd ? rd_sel : 8'h00;
			ch0_code          <= code0;
			ch1_code          <= code1;
			ch0_output_enable <= ctl0[ddu_pkg::ENABLE_BIT];
			ch1_output_enable <= ctl1[ddu_pkg::ENABLE_BIT];
			ch0_shutdown      <= !ctl0[ddu_pkg::ENABLE_BIT];
			ch1_shutdown      <= !ctl1[ddu_pkg::ENABLE_BIT];
		end
	end

endmodule

`default_nettype wire

/* bench/ddu_properties.sv */
// Port checker for channel 0 of the dual converter update formatter
`timescale 1ns/10ps
`default_nettype none
module ddu_properties (
	// Clock, reset and register port
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_wdata,
	input wire logic [7:0]  sfr_rdata,
	// Timers and channel 0
	input wire logic        timer2_overflow,
	input wire logic        timer3_overflow,
	input wire logic        timer4_overflow,
	input wire logic [11:0] ch0_code,
	input wire logic        ch0_output_enable,
	input wire logic        ch0_shutdown
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// ----
	// Shadow of channel 0; hist marks the settling window after a cause
	// ----
	logic [7:0]  lo, hi, hl, ll, ctl;
	logic [3:0]  hist;
	wire         wr_hi = sfr_wr && sfr_addr == 8'hd3;
	wire         wr_ct = sfr_wr && sfr_addr == 8'hd4;
	wire  [3:0]  tsel  = {timer2_overflow, timer4_overflow, timer3_overflow, wr_hi};
	wire         upd   = tsel[ctl[4:3]];
	wire  [15:0] word  = {hl, ll} >> (ctl[2] ? 3'h4 : {1'b0, ctl[1:0]});
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			{lo, hi, hl, ll, ctl, hist} <= '0;
		end else begin
			if (sfr_wr && sfr_addr == 8'hd2) lo <= sfr_wdata;
			if (wr_hi) hi <= sfr_wdata;
			if (wr_ct) ctl <= sfr_wdata & 8'h9f;
			// A byte written in the cycle of the update is part of it
			if (upd) hl <= wr_hi ? sfr_wdata : hi;
			if (upd) ll <= (sfr_wr && sfr_addr == 8'hd2) ? sfr_wdata : lo;
			hist <= {hist[2:0], upd | wr_ct};
		end
	end
	sequence s_ctl_quiet; $stable(ctl) [*3]; endsequence
	property p_pin_pair; ch0_output_enable != ch0_shutdown; endproperty
	a_pin_pair: assert property (p_pin_pair) else $error("enable and shutdown agree");
	property p_en_follow; s_ctl_quiet |-> ch0_output_enable == ctl[7]; endproperty
	a_en_follow: assert property (p_en_follow) else $error("enable differs");
	property p_rd_idle; !sfr_rd |=> sfr_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
	property p_ctl_read; sfr_rd && sfr_addr == 8'hd4 |=> sfr_rdata == ctl; endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("control readback");
	property p_low_read; sfr_rd && sfr_addr == 8'hd2 |=> sfr_rdata == lo; endproperty
	a_low_read: assert property (p_low_read) else $error("low readback");
	property p_high_read; sfr_rd && sfr_addr == 8'hd3 |=> sfr_rdata == hl; endproperty
	a_high_read: assert property (p_high_read) else $error("high readback");
	property p_code_value; hist == 4'h0 |-> ch0_code == word[11:0]; endproperty
	a_code_value: assert property (p_code_value) else $error("code value");
	property p_code_cause; $changed(ch0_code) |-> hist != 4'h0; endproperty
	a_code_cause: assert property (p_code_cause) else $error("code moved");
endmodule
`default_nettype wire

/* bench/ddu_sfr_host.sv */
// Processor-side model: register strobes and timer overflow pulses
`timescale 1ns/10ps
`default_nettype none
module ddu_sfr_host (
	// Clock and read data
	input  wire logic      core_clk,
	input  wire logic [7:0] sfr_rdata,
	// Strobes and timers
	output var logic [7:0] sfr_addr,
	output var logic       sfr_wr,
	output var logic       sfr_rd,
	output var logic [7:0] sfr_wdata,
	output var logic [2:0] timer_pulse
);
	initial begin
		{sfr_addr, sfr_wr, sfr_rd, sfr_wdata, timer_pulse} = '0;
	end
	// Bus is inverted after each strobe so stale values never pass for live
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		{sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
		@(negedge core_clk);
		{sfr_addr, sfr_wdata, sfr_wr} = {~a, ~d, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		{sfr_addr, sfr_rd} = {a, 1'b1};
		@(negedge core_clk);
		d = sfr_rdata;
		{sfr_addr, sfr_rd} = {~a, 1'b0};
	endtask
	task automatic tick(input logic [2:0] m);
		@(negedge core_clk);
		timer_pulse = m;
		@(negedge core_clk);
		timer_pulse = 3'h0;
	endtask
endmodule
`default_nettype wire

/* bench/dual_dac_update_formatter_tb_top.sv */
// Self-checking bench for the dual converter update formatter
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module dual_dac_update_formatter_tb_top;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rv;
	logic        sfr_wr, sfr_rd, en0, en1, sd0, sd1;
	logic [2:0]  tp;
	logic [11:0] ch0_code, ch1_code, exp0;
	int          fail_count = 0;
	int          samples_checked = 0;
	ddu_sfr_host HOST (.core_clk(core_clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .timer_pulse(tp));
	ddu_top DUT (.core_clk(core_clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer2_overflow(tp[2]),
		.timer3_overflow(tp[0]), .timer4_overflow(tp[1]), .ch0_code(ch0_code),
		.ch1_code(ch1_code), .ch0_output_enable(en0), .ch1_output_enable(en1),
		.ch0_shutdown(sd0), .ch1_shutdown(sd1));
	function automatic logic [11:0] fmt(input logic [2:0] f, input logic [15:0] w);
		fmt = 12'(w >> (f[2] ? 3'h4 : {1'b0, f[1:0]}));
	endfunction
	task automatic final_report;
		$display("checked %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		repeat (5) @(negedge core_clk);
		resetn = 1'b1;
		`CHK({en0, sd0}, 2'b01)
		for (int a = 8'hd1; a < 8'hd8; a++) begin
			HOST.rd(8'(a), rv);
			`CHK(rv, 8'h00)
		end
		for (int f = 0; f < 8; f++) begin
			HOST.wr(8'hd4, 8'he0 | 8'(f));
			HOST.wr(8'hd2, 8'h9b);
			HOST.wr(8'hd3, 8'hc6 + 8'(f));
			repeat (4) @(negedge core_clk);
			`CHK(ch0_code, fmt(3'(f), {8'hc6 + 8'(f), 8'h9b}))
		end
		HOST.rd(8'hd4, rv);
		`CHK({rv, en0, sd0}, {8'h87, 2'b10})
		HOST.wr(8'hd2, 8'h00);
		HOST.tick(3'h7);
		repeat (4) @(negedge core_clk);
		`CHK(ch0_code, fmt(3'h7, {8'hcd, 8'h9b}))
		HOST.rd(8'hd2, rv);
		`CHK(rv, 8'h00)
		HOST.rd(8'hd3, rv);
		`CHK(rv, 8'hcd)
		exp0 = fmt(3'h0, {8'hcd, 8'h9b});
		for (int m = 1; m < 4; m++) begin
			HOST.wr(8'hd4, 8'h80 | 8'(m << 3));
			HOST.wr(8'hd2, 8'h30 + 8'(m));
			HOST.wr(8'hd3, 8'h50 + 8'(m));
			HOST.tick(3'(~(3'h1 << (m - 1))));
			repeat (4) @(negedge core_clk);
			`CHK(ch0_code, exp0)
			HOST.tick(3'(3'h1 << (m - 1)));
			repeat (4) @(negedge core_clk);
			exp0 = fmt(3'h0, {8'h50 + 8'(m), 8'h30 + 8'(m)});
			`CHK(ch0_code, exp0)
		end
		HOST.wr(8'hd7, 8'h84);
		HOST.wr(8'hd5, 8'ha5);
		HOST.wr(8'hd6, 8'h3c);
		repeat (4) @(negedge core_clk);
		`CHK({en1, sd1, ch1_code, ch0_code}, {2'b10, 12'h3ca, exp0})
		HOST.wr(8'hd7, 8'hf8);
		HOST.rd(8'hd7, rv);
		`CHK(rv, 8'h98)
		HOST.wr(8'hd5, 8'h11);
		HOST.wr(8'hd6, 8'h22);
		HOST.rd(8'hd5, rv);
		`CHK(rv, 8'h11)
		HOST.rd(8'hd6, rv);
		`CHK({rv, ch1_code}, {8'h3c, 12'hca5})
		HOST.tick(3'h4);
		repeat (4) @(negedge core_clk);
		`CHK({ch1_code, ch0_code}, {fmt(3'h0, {8'h22, 8'h11}), exp0})
		HOST.wr(8'hd4, 8'h00);
		repeat (2) @(negedge core_clk);
		`CHK({en0, sd0}, 2'b01)
		resetn = 1'h0;
		repeat (2) @(negedge core_clk);
		resetn = 1'h1;
		`CHK({en1, sd1, ch1_code}, {2'h1, 12'h000})
		HOST.rd(8'hd6, rv);
		`CHK(rv, 8'h00)
		final_report();
	end
endmodule
bind ddu_top ddu_properties CHECK (.core_clk(core_clk), .resetn(resetn), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.timer2_overflow(timer2_overflow), .timer3_overflow(timer3_overflow),
	.timer4_overflow(timer4_overflow), .ch0_code(ch0_code),
	.ch0_output_enable(ch0_output_enable), .ch0_shutdown(ch0_shutdown));
`default_nettype wire
